// file: design/rwc_map.svh
// Register offsets, field positions, reset values and timing constants
`ifndef RWC_MAP_SVH
`define RWC_MAP_SVH
`define RWC_OFF_CAUSE 8'h00
`define RWC_OFF_OPT 8'h04
`define RWC_OFF_PEND 8'h08
`define RWC_OFF_WAKE_EN 8'h0c
`define RWC_OFF_STAT 8'h10
`define RWC_BIT_POR 7
`define RWC_BIT_PIN 6
`define RWC_BIT_WDT 5
`define RWC_BIT_ILLEGAL_OPCODE_RESET 4
`define RWC_BIT_ILLEGAL_ADDRESS_RESET 3
`define RWC_BIT_LVD 1
`define RWC_OPT_WDEN 7
`define RWC_OPT_WDTSEL 6
`define RWC_OPT_PINEN 0
`define RWC_OPT_RESET 8'hc0
`define RWC_FETCH_ADDR 14'h3ffd
`define RWC_SHORT_LOG2 5
`define RWC_LONG_LOG2 8
`define RWC_REF_PERIOD_US 1000
`define RWC_CLK_PERIOD_PS 4000
`define RWC_RESP_OKAY 2'h0
`define RWC_RESP_SLVERR 2'h2
`endif

// file: design/rwc_pkg.sv
// Types shared by the reset, watchdog and wakeup control block
package rwc_pkg;
    typedef enum logic [2:0] {
        RWC_RUN = 3'b001,
        RWC_RST = 3'b010,
        RWC_STOP = 3'b100
    } rwc_state_t;
endpackage : rwc_pkg

// file: design/rwc_ctrl.sv
// Reset cause capture, watchdog and wakeup pending logic
// Behaviour
// - Reset starts fetch at 3FFD, registers reinitialised
// - Peripherals disabled, pins float during reset
// - Seven reset causes, pin needs enable
// - Each cause except debugger has flag
// - Watchdog enabled after reset; clearing stops it
// - Write to cause register restarts watchdog
// - Watchdog overflow generates system reset
// - Counts 1-kHz ticks, 2^5 or 2^8
// - Options register write-once; write restarts watchdog
// - Watchdog holds during background debug
// - Stop clears watchdog; restarts on exit
// - No vectors; requests only wake CPU
// - Wake enables gate wakeup, not flags
// - Pending register read-only, one bit per module
// - Pending clears when module flags clear
// - Power-on sets power-on and low-voltage flags
// - Debugger reset clears all cause flags
`timescale 1ns/1ps
`default_nettype none
`include "rwc_map.svh"
module rwc_ctrl #(
    parameter int NMOD = 5,
    parameter int REF_DIV = 250000
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic por_i,
    input wire logic reset_pin_n_i,
    input wire logic low_voltage_detect_i,
    input wire logic illegal_opcode_reset_i,
    input wire logic illegal_address_reset_i,
    input wire logic debugger_forced_reset_i,
    input wire logic bdm_active_i,
    input wire logic stop_mode_i,
    input wire logic [NMOD-1:0] module_flags_i,
    output logic sys_reset_o,
    output logic periph_enable_o,
    output logic pin_hiz_o,
    output logic [13:0] fetch_addr_o,
    output logic wakeup_o,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    rwc_pkg::rwc_state_t state_reg;
    logic [2:0] pin_sync_reg;
    logic pin_n_stable_reg;
    logic [7:0] cause_reg;
    logic [7:0] opt_reg;
    logic opt_locked_reg;
    logic [NMOD-1:0] wake_en_reg;
    logic [NMOD-1:0] pend_reg;
    logic [31:0] div_reg;
    logic tick;
    logic [8:0] wdt_reg;
    logic wdt_restart_req_reg;
    logic wdt_overflow;
    logic stop_prev_reg;
    logic [7:0] aw_addr_reg;
    logic aw_full_reg;
    logic [31:0] w_data_reg;
    logic w_full_reg;
    logic [3:0] w_strb_reg;
    logic bad_wr;
    logic cause_wr;
    logic opt_wr;
    logic wake_wr;
    logic [31:0] rdata_next;
    logic rd_ok;
    logic pin_event;
    logic any_cause;

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == `RWC_OFF_CAUSE) || (a == `RWC_OFF_OPT) || (a == `RWC_OFF_PEND)
            || (a == `RWC_OFF_WAKE_EN) || (a == `RWC_OFF_STAT);
    endfunction : known_addr

    // Pin is asynchronous; three stages, act on agreement of the last two
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pin_sync_reg <= 3'h7;
            pin_n_stable_reg <= 1'b1;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], reset_pin_n_i};
            if (pin_sync_reg[1] == pin_sync_reg[2]) begin
                pin_n_stable_reg <= pin_sync_reg[2];
            end
        end
    end

    assign pin_event = !pin_n_stable_reg && opt_reg[`RWC_OPT_PINEN];
    assign any_cause = pin_event || low_voltage_detect_i || wdt_overflow
        || illegal_opcode_reset_i || illegal_address_reset_i || debugger_forced_reset_i;

    // Reset sequencing: one cycle of internal reset per event
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || por_i) begin
            state_reg <= rwc_pkg::RWC_RST;
        end else begin
            case (state_reg)
                rwc_pkg::RWC_RUN: begin
                    if (any_cause) begin
                        state_reg <= rwc_pkg::RWC_RST;
                    end else if (stop_mode_i) begin
                        state_reg <= rwc_pkg::RWC_STOP;
                    end
                end
                rwc_pkg::RWC_STOP: begin
                    if (any_cause) begin
                        state_reg <= rwc_pkg::RWC_RST;
                    end else if (!stop_mode_i) begin
                        state_reg <= rwc_pkg::RWC_RUN;
                    end
                end
                rwc_pkg::RWC_RST: begin
                    state_reg <= rwc_pkg::RWC_RUN;
                end
                default: begin
                    state_reg <= rwc_pkg::RWC_RST;
                end
            endcase
        end
    end

    assign sys_reset_o = (state_reg == rwc_pkg::RWC_RST);
    assign periph_enable_o = !sys_reset_o;
    assign pin_hiz_o = sys_reset_o;
    assign fetch_addr_o = `RWC_FETCH_ADDR;

    // Cause flags record only the latest reset
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || por_i) begin
            cause_reg <= 8'h00;
            cause_reg[`RWC_BIT_POR] <= 1'b1;
            cause_reg[`RWC_BIT_LVD] <= 1'b1;
        end else if (state_reg != rwc_pkg::RWC_RST && any_cause) begin
            cause_reg <= 8'h00;
            if (!debugger_forced_reset_i) begin
                cause_reg[`RWC_BIT_PIN] <= pin_event;
                cause_reg[`RWC_BIT_WDT] <= wdt_overflow;
                cause_reg[`RWC_BIT_ILLEGAL_OPCODE_RESET] <= illegal_opcode_reset_i;
                cause_reg[`RWC_BIT_ILLEGAL_ADDRESS_RESET] <= illegal_address_reset_i;
                cause_reg[`RWC_BIT_LVD] <= low_voltage_detect_i;
            end
        end
    end

    // Options: write-once after any reset, defaults reloaded on reset
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || sys_reset_o) begin
            opt_reg <= `RWC_OPT_RESET;
            opt_locked_reg <= 1'b0;
        end else if (opt_wr && !opt_locked_reg) begin
            opt_reg <= w_data_reg[7:0];
            opt_locked_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i || sys_reset_o) begin
            wake_en_reg <= '0;
        end else if (wake_wr) begin
            wake_en_reg <= w_data_reg[NMOD-1:0];
        end
    end

    // Pending follows module flags; no acknowledge, no vector
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= module_flags_i;
        end
    end
    assign wakeup_o = |(pend_reg & wake_en_reg);

    // Reference tick as a one-cycle enable on the single clock
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || div_reg == 32'(REF_DIV - 1)) begin
            div_reg <= 32'h0;
        end else begin
            div_reg <= div_reg + 32'h1;
        end
    end
    assign tick = (div_reg == 32'(REF_DIV - 1));

    // Restart held until the next tick so no write is lost at a tick edge
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || sys_reset_o) begin
            wdt_restart_req_reg <= 1'b1;
        end else if (cause_wr || (opt_wr && !opt_locked_reg)) begin
            wdt_restart_req_reg <= 1'b1;
        end else if (tick) begin
            wdt_restart_req_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        stop_prev_reg <= reset_i ? 1'b0 : stop_mode_i;
    end

    assign wdt_overflow = opt_reg[`RWC_OPT_WDEN] && (opt_reg[`RWC_OPT_WDTSEL] ?
        wdt_reg[`RWC_LONG_LOG2] : wdt_reg[`RWC_SHORT_LOG2]) && !sys_reset_o;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i || sys_reset_o) begin
            wdt_reg <= 9'h0;
        end else if (stop_mode_i || (stop_mode_i && !stop_prev_reg)) begin
            wdt_reg <= 9'h0;
        end else if (cause_wr || (opt_wr && !opt_locked_reg)) begin
            wdt_reg <= 9'h0;
        end else if (tick && wdt_restart_req_reg) begin
            wdt_reg <= 9'h0;
        end else if (tick && !bdm_active_i && opt_reg[`RWC_OPT_WDEN]) begin
            wdt_reg <= wdt_reg + 9'h1;
        end
    end

    // AXI4-Lite write: address and data taken in either order
    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RWC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                // Strobes ride with the data beat; master may drop them once taken
                w_strb_reg <= s_axi_wstrb;
            end
            if (aw_full_reg && w_full_reg) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= bad_wr ? `RWC_RESP_SLVERR : `RWC_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    wire wr_go = aw_full_reg && w_full_reg;
    assign bad_wr = !known_addr(aw_addr_reg);
    // Any write to the cause address restarts; contents stay put
    assign cause_wr = wr_go && aw_addr_reg == `RWC_OFF_CAUSE;
    assign opt_wr = wr_go && aw_addr_reg == `RWC_OFF_OPT && w_strb_reg[0];
    assign wake_wr = wr_go && aw_addr_reg == `RWC_OFF_WAKE_EN && w_strb_reg[0];

    // AXI4-Lite read
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_ok = known_addr(s_axi_araddr);
    always_comb begin
        rdata_next = 32'h0;
        case (s_axi_araddr)
            `RWC_OFF_CAUSE: rdata_next[7:0] = cause_reg;
            `RWC_OFF_OPT: rdata_next[7:0] = opt_reg;
            `RWC_OFF_PEND: rdata_next[NMOD-1:0] = pend_reg;
            `RWC_OFF_WAKE_EN: rdata_next[NMOD-1:0] = wake_en_reg;
            `RWC_OFF_STAT: rdata_next[9:0] = {opt_locked_reg, wdt_reg};
            default: rdata_next = 32'h0;
        endcase
    end
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RWC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_next;
            s_axi_rresp <= rd_ok ? `RWC_RESP_OKAY : `RWC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    sequence wd_pulse_s;
        tick && wdt_restart_req_reg;
    endsequence

    por_flags_a: assert property (@(posedge clk_sys_i)
        por_i |=> cause_reg[`RWC_BIT_POR] && cause_reg[`RWC_BIT_LVD])
        else $error("power-on flags missing");
    dbg_clear_a: assert property (@(posedge clk_sys_i) disable iff (reset_i || por_i)
        (state_reg == rwc_pkg::RWC_RUN && debugger_forced_reset_i) |=> cause_reg == 8'h00)
        else $error("debugger reset left flags");
    wd_enable_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sys_reset_o |=> opt_reg[`RWC_OPT_WDEN])
        else $error("watchdog not enabled after reset");
    wd_restart_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (cause_wr && !sys_reset_o) |=> wdt_reg == 9'h0 && $stable(cause_reg))
        else $error("restart write failed");
    wd_fire_a: assert property (@(posedge clk_sys_i) disable iff (reset_i || por_i)
        (wdt_overflow && state_reg == rwc_pkg::RWC_RUN) |=> sys_reset_o)
        else $error("overflow gave no reset");
    opt_once_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (opt_locked_reg && !sys_reset_o) |=> $stable(opt_reg) || sys_reset_o || $past(sys_reset_o))
        else $error("options changed after lock");
    bdm_hold_a: assert property (@(posedge clk_sys_i) disable iff (reset_i || sys_reset_o)
        (bdm_active_i && !stop_mode_i && !wr_go && !(tick && wdt_restart_req_reg))
        |=> wdt_reg == $past(wdt_reg))
        else $error("counter moved in debug");
    stop_zero_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        stop_mode_i |=> wdt_reg == 9'h0)
        else $error("counter not cleared in stop");
    wake_gate_a: assert property (@(posedge clk_sys_i) disable iff (reset_i || sys_reset_o)
        (|module_flags_i && wake_en_reg == '0 && !wake_wr) |=> |pend_reg && !wakeup_o)
        else $error("masked source lost its flag or woke");
    pend_follow_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ##1 pend_reg == $past(module_flags_i))
        else $error("pending does not follow flags");
    wd_pulse_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wd_pulse_s |=> wdt_reg == 9'h0)
        else $error("held restart not applied at tick");
endmodule : rwc_ctrl
`default_nettype wire

// file: tb/rwc_cpu_model.sv
// CPU side model: AXI4-Lite master issuing single accesses
`timescale 1ns/1ps
`default_nettype none
module rwc_cpu_model (
    input wire logic clk_i,
    output logic [7:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic [1:0] bresp_i,
    input wire logic bvalid_i,
    output logic bready_o,
    output logic [7:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    input wire logic rvalid_i,
    output logic rready_o
);
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
    end
    // Released payloads are inverted so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, b;
        b = 1'b0;
        @(posedge clk_i);
        awaddr_o <= a;
        wdata_o <= d;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        while (!b) begin
            @(negedge clk_i);
            aw = awvalid_o && awready_i;
            w = wvalid_o && wready_i;
            b = bvalid_i;
            r = bresp_i;
            @(posedge clk_i);
            if (aw) begin
                awvalid_o <= 1'b0;
                awaddr_o <= ~a;
            end
            if (w) begin
                wvalid_o <= 1'b0;
                wdata_o <= ~d;
            end
            if (b) begin
                bready_o <= 1'b0;
            end
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, v;
        v = 1'b0;
        @(posedge clk_i);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        while (!v) begin
            @(negedge clk_i);
            ar = arvalid_o && arready_i;
            v = rvalid_i;
            d = rdata_i;
            r = rresp_i;
            @(posedge clk_i);
            if (ar) begin
                arvalid_o <= 1'b0;
                araddr_o <= ~a;
            end
            if (v) begin
                rready_o <= 1'b0;
            end
        end
    endtask : rd
endmodule : rwc_cpu_model
`default_nettype wire

// file: tb/reset_watchdog_wakeup_ctrl_test.sv
// Self-checking bench for the reset, watchdog and wakeup block
`timescale 1ns/1ps
`default_nettype none
module reset_watchdog_wakeup_ctrl_test;
    logic clk_sys_i, reset_i, por_i, pin_n, low_voltage_detect, illegal_opcode_reset, illegal_address_reset, dbg, bdm, stp;
    logic sys_rst, pen, hiz, wake, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
    logic [4:0] flags;
    logic [13:0] fa;
    logic [7:0] awa, ara;
    logic [31:0] lfsr, rd, wd, rdat;
    logic [1:0] rs, bresp, rresp;
    logic [31:0] causes [5] = '{32'h02, 32'h10, 32'h08, 32'h00, 32'h82};
    int mismatches = 0;
    int checks = 0;
    int n;
    // Short reference divide keeps watchdog spans within the run
    rwc_ctrl #(.NMOD(5), .REF_DIV(4)) u_dut (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .por_i(por_i), .reset_pin_n_i(pin_n),
        .low_voltage_detect_i(low_voltage_detect), .illegal_opcode_reset_i(illegal_opcode_reset),
        .illegal_address_reset_i(illegal_address_reset), .debugger_forced_reset_i(dbg),
        .bdm_active_i(bdm), .stop_mode_i(stp), .module_flags_i(flags),
        .sys_reset_o(sys_rst), .periph_enable_o(pen), .pin_hiz_o(hiz), .fetch_addr_o(fa),
        .wakeup_o(wake), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr));
    rwc_cpu_model u_cpu (
        .clk_i(clk_sys_i), .awaddr_o(awa), .awvalid_o(awv), .awready_i(awr), .wdata_o(wd),
        .wvalid_o(wv), .wready_i(wrd), .bresp_i(bresp), .bvalid_i(bv), .bready_o(br),
        .araddr_o(ara), .arvalid_o(arv), .arready_i(arr), .rdata_i(rdat), .rresp_i(rresp),
        .rvalid_i(rv), .rready_o(rr));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        u_cpu.rd(a, rd, rs);
        chk("rdata", rd, exp);
        chk("rresp", {30'h0, rs}, (a > 8'h10) ? 32'h2 : 32'h0);
    endtask : rchk
    task automatic wait_rst(input int lim);
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (sys_rst !== 1'b1 && n < lim);
    endtask : wait_rst
    task automatic resetcheck(input int lim, input logic [31:0] cause);
        wait_rst(lim);
        chk("hiz", {31'h0, hiz}, 32'h1);
        chk("pen", {31'h0, pen}, 32'h0);
        repeat (4) @(negedge clk_sys_i);
        chk("rst_end", {31'h0, sys_rst}, 32'h0);
        rchk(8'h00, cause);
        rchk(8'h04, 32'hc0);
    endtask : resetcheck
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        complete_run();
    end
    initial begin
        {por_i, low_voltage_detect, illegal_opcode_reset, illegal_address_reset, dbg, bdm, stp, flags} = '0;
        {reset_i, pin_n} = 2'b11;
        lfsr = 32'hef6f;
        repeat (5) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        resetcheck(20, 32'h82);
        chk("fetch", {18'h0, fa}, 32'h3ffd);
        rchk(8'h14, 32'h0);
        u_cpu.wr(8'h14, lfsr, rs);
        chk("bresp_bad", {30'h0, rs}, 32'h2);
        for (int i = 0; i < 6; i++) begin
            lfsr = nxt(lfsr);
            @(posedge clk_sys_i);
            flags <= lfsr[4:0];
            u_cpu.wr(8'h0c, {27'h0, lfsr[9:5]}, rs);
            u_cpu.wr(8'h08, 32'hffffffff, rs);
            chk("bresp", {30'h0, rs}, 32'h0);
            rchk(8'h08, {27'h0, lfsr[4:0]});
            chk("wake", {31'h0, wake}, {31'h0, |(lfsr[4:0] & lfsr[9:5])});
            u_cpu.wr(8'h00, lfsr, rs);
            rchk(8'h00, 32'h82);
        end
        @(posedge clk_sys_i);
        flags <= 5'h0;
        rchk(8'h08, 32'h0);
        repeat (40) @(posedge clk_sys_i);
        bdm <= 1'b1;
        u_cpu.rd(8'h10, rd, rs);
        repeat (40) @(posedge clk_sys_i);
        rchk(8'h10, rd);
        bdm <= 1'b0;
        stp <= 1'b1;
        repeat (40) @(posedge clk_sys_i);
        rchk(8'h10, rd & 32'h200);
        stp <= 1'b0;
        u_cpu.wr(8'h04, 32'h80, rs);
        u_cpu.wr(8'h04, 32'h41, rs);
        chk("bresp_opt", {30'h0, rs}, 32'h0);
        rchk(8'h04, 32'h80);
        repeat (80) @(posedge clk_sys_i);
        u_cpu.wr(8'h00, 32'h0, rs);
        resetcheck(300, 32'h20);
        chk("span", {31'h0, n >= 110 && n <= 150}, 32'h1);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys_i);
            {por_i, dbg, illegal_address_reset, illegal_opcode_reset, low_voltage_detect} <= 5'h1 << i;
            @(posedge clk_sys_i);
            {por_i, dbg, illegal_address_reset, illegal_opcode_reset, low_voltage_detect} <= 5'h0;
            resetcheck(20, causes[i]);
        end
        pin_n <= 1'b0;
        wait_rst(20);
        chk("pin_off", n, 20);
        @(posedge clk_sys_i);
        pin_n <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        u_cpu.wr(8'h04, 32'h01, rs);
        wait_rst(1300);
        chk("no_wdt", n, 1300);
        @(posedge clk_sys_i);
        pin_n <= 1'b0;
        resetcheck(20, 32'h40);
        pin_n <= 1'b1;
        complete_run();
    end
endmodule : reset_watchdog_wakeup_ctrl_test
`default_nettype wire
